// *** design/hbi_host_if.v ***
// Host bus interface: parallel (three styles) and SPI slave with mode detect.
// Assumes pins arrive asynchronous; register file outside answers reads
// combinationally on i_rd_data for o_rd_addr, and drains writes via FIFO.
//
// Function
// - After reset return to parallel mode, then detect interface type.
// - Interface type decoded from strapped control pin levels.
// - Separate strobes: read, write, chip select, 3 or 6-bit address.
// - Common strobe: read/write select, data strobe, chip select, address.
// - Handshake mode: multiplexed bus with write select, strobes, wait.
// - Chip select gates handshake data strobe; tie low if unused.
// - Wait output stays high impedance after reset.
// - Wait driven only after first falling address strobe edge.
// - Serial mode is SPI slave only; master clocks SCK.
// - First SPI byte carries direction and register address.
// - SPI read: bit 7 high, address in bits 6..1.
// - SPI read pipelined: MISO returns data of previous address.
// - SPI write: bit 7 low, address in bits 6..1, then data.
// - SPI write puts every data byte to the same address.
// - Mux modes capture address on latch high or handshake strobe low.
// - Wait low begins an access, high ends it.
// - Common strobe: read/write select decides cycle direction.
`timescale 1ns/1ps
`include "hbi_map.vh"
`default_nettype none
module hbi_host_if #(
    parameter FIFO_DEPTH = `HBI_FIFO_DEPTH,
    parameter FIFO_AW = `HBI_FIFO_AW
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_ce,
    input wire i_latch,
    input wire [2:0] i_addr_pin,
    input wire i_read_strobe_n,
    input wire i_write_strobe_n,
    input wire i_chip_select_n,
    input wire [7:0] i_data_pin,
    output reg [7:0] o_data_pin,
    output reg o_data_oe,
    output reg o_addr0_pin,
    output reg o_addr0_oe,
    output reg [2:0] o_mode,
    output reg o_mode_valid,
    output reg [5:0] o_rd_addr,
    output reg o_rd_req,
    input wire [7:0] i_rd_data,
    output wire o_wr_valid,
    input wire i_wr_ready,
    output wire [5:0] o_wr_addr,
    output wire [7:0] o_wr_data,
    output reg o_busy
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Not reset on purpose: straps must flow through while reset
    // is held, so detection sees the real pin levels
    reg [14:0] s1_ff;
    reg [14:0] s2_ff;
    reg [14:0] s3_ff;
    always @(posedge i_ref_clk) begin
        if (i_ce) begin
            s1_ff <= {i_latch, i_addr_pin, i_read_strobe_n, i_write_strobe_n,
                      i_chip_select_n, i_data_pin};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    wire latch = s2_ff[14];
    wire [2:0] apin = s2_ff[13:11];
    wire rd_n = s2_ff[10];
    wire wr_n = s2_ff[9];
    wire cs_n = s2_ff[8];
    wire [7:0] din = s2_ff[7:0];
    wire latch_p = s3_ff[14];
    wire sck_p = s3_ff[13];
    wire rd_n_p = s3_ff[10];
    wire wr_n_p = s3_ff[9];

    // ----------------------------------------------------------------
    // Mode detection
    // ----------------------------------------------------------------
    localparam ST_DET = 2'h0;
    localparam ST_RUN = 2'h1;
    reg [1:0] st_ff;
    reg [2:0] nxt_mode;
    always @* begin
        if (latch && apin == `HBI_STRAP_SPI && rd_n && wr_n && !cs_n)
            nxt_mode = `HBI_MODE_SPI;
        // Handshake address strobe idles high, so its level is left out
        else if (apin[2] && apin[1] && !cs_n)
            nxt_mode = `HBI_MODE_HSK;
        else if (apin == `HBI_STRAP_SEP_MUX)
            nxt_mode = `HBI_MODE_SEP_MUX;
        else if (apin == `HBI_STRAP_COM_MUX)
            nxt_mode = `HBI_MODE_COM_MUX;
        else if (rd_n && wr_n)
            nxt_mode = `HBI_MODE_SEP_DED;
        else
            nxt_mode = `HBI_MODE_COM_DED;
    end

    // ----------------------------------------------------------------
    // Access engine
    // ----------------------------------------------------------------
    reg [5:0] addr_ff;
    reg hs_arm_ff;
    reg [3:0] bit_ff;
    reg [7:0] sh_ff;
    reg [7:0] tx_ff;
    reg first_ff;
    reg spi_rd_ff;
    reg wr_v;
    reg [13:0] wr_d;
    wire wr_rdy;
    wire sel = !cs_n;
    // A byte arriving while the staged one drains is still queued
    wire wr_free = !wr_v || wr_rdy;
    wire sck_rise = apin[2] && !sck_p;
    wire sck_fall = !apin[2] && sck_p;
    wire [7:0] sh_next = {sh_ff[6:0], apin[0]};
    // chip select inhibits the handshake data strobe
    wire hs_ds_act = !rd_n && !cs_n;
    wire hs_ds_fall = hs_ds_act && !(!rd_n_p && !cs_n);
    wire hs_ds_rise = !hs_ds_act && !rd_n_p;
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            st_ff <= ST_DET;
            o_mode <= `HBI_MODE_SEP_DED;
            o_mode_valid <= 1'b0;
            o_data_pin <= 8'h00;
            o_data_oe <= 1'b0;
            o_addr0_pin <= 1'b1;
            o_addr0_oe <= 1'b0;
            addr_ff <= 6'h00;
            hs_arm_ff <= 1'b0;
            o_rd_addr <= 6'h00;
            o_rd_req <= 1'b0;
            bit_ff <= 4'h0;
            sh_ff <= 8'h00;
            tx_ff <= 8'h00;
            first_ff <= 1'b1;
            spi_rd_ff <= 1'b0;
            wr_v <= 1'b0;
            wr_d <= 14'h0000;
            o_busy <= 1'b0;
        end else if (i_ce) begin
            o_rd_req <= 1'b0;
            o_busy <= wr_v && !wr_rdy;
            if (wr_v && wr_rdy)
                wr_v <= 1'b0;
            case (st_ff)
                ST_DET: begin
                    o_mode <= nxt_mode;
                    o_mode_valid <= 1'b1;
                    st_ff <= ST_RUN;
                end
                ST_RUN: begin
                    case (o_mode)
                        `HBI_MODE_SEP_DED, `HBI_MODE_SEP_MUX: begin
                            if (o_mode == `HBI_MODE_SEP_MUX && latch)
                                addr_ff <= din[5:0];
                            o_data_oe <= sel && !rd_n;
                            if (sel && !rd_n && rd_n_p) begin
                                o_rd_addr <= (o_mode == `HBI_MODE_SEP_DED) ?
                                    {3'h0, apin} : addr_ff;
                                o_rd_req <= 1'b1;
                            end
                            o_data_pin <= i_rd_data;
                            if (sel && wr_n && !wr_n_p && wr_free) begin
                                wr_v <= 1'b1;
                                wr_d <= {(o_mode == `HBI_MODE_SEP_DED) ?
                                    {3'h0, apin} : addr_ff, din};
                            end
                        end
                        `HBI_MODE_COM_DED, `HBI_MODE_COM_MUX: begin
                            if (o_mode == `HBI_MODE_COM_MUX && latch)
                                addr_ff <= din[5:0];
                            o_data_oe <= sel && !rd_n && wr_n;
                            if (sel && !rd_n && rd_n_p && wr_n) begin
                                o_rd_addr <= (o_mode == `HBI_MODE_COM_DED) ?
                                    {3'h0, apin} : addr_ff;
                                o_rd_req <= 1'b1;
                            end
                            o_data_pin <= i_rd_data;
                            if (rd_n && !rd_n_p && !wr_n && sel && wr_free) begin
                                wr_v <= 1'b1;
                                wr_d <= {(o_mode == `HBI_MODE_COM_DED) ?
                                    {3'h0, apin} : addr_ff, din};
                            end
                        end
                        `HBI_MODE_HSK: begin
                            if (!latch)
                                addr_ff <= din[5:0];
                            // arm wait on first address strobe fall
                            if (!latch && latch_p)
                                hs_arm_ff <= 1'b1;
                            // handshake wait on low address pin
                            o_addr0_oe <= hs_arm_ff;
                            if (hs_ds_fall) begin
                                o_addr0_pin <= 1'b0;
                                if (wr_n) begin
                                    o_rd_addr <= addr_ff;
                                    o_rd_req <= 1'b1;
                                end else if (wr_free) begin
                                    wr_v <= 1'b1;
                                    wr_d <= {addr_ff, din};
                                end
                            end else if (hs_ds_rise)
                                o_addr0_pin <= 1'b1;
                            o_data_oe <= hs_ds_act && wr_n;
                            o_data_pin <= i_rd_data;
                        end
                        default: begin
                            o_data_oe <= 1'b1;
                            if (latch) begin
                                bit_ff <= 4'h0;
                                first_ff <= 1'b1;
                            end else if (sck_rise) begin
                                sh_ff <= sh_next;
                                bit_ff <= bit_ff + 4'h1;
                                if (bit_ff == `HBI_SPI_LAST_BIT) begin
                                    bit_ff <= 4'h0;
                                    first_ff <= 1'b0;
                                    if (first_ff) begin
                                        // first byte is mode and address
                                        spi_rd_ff <= sh_next[`HBI_SPI_DIR_BIT];
                                        addr_ff <= sh_next[`HBI_SPI_ADDR_HI:
                                            `HBI_SPI_ADDR_LO];
                                    end
                                    if (first_ff ? sh_next[`HBI_SPI_DIR_BIT] :
                                        spi_rd_ff) begin
                                        o_rd_addr <= sh_next[`HBI_SPI_ADDR_HI:
                                            `HBI_SPI_ADDR_LO];
                                        o_rd_req <= 1'b1;
                                    end else if (!first_ff && wr_free) begin
                                        wr_v <= 1'b1;
                                        wr_d <= {addr_ff, sh_next};
                                    end
                                end
                            end
                            if (o_rd_req)
                                tx_ff <= i_rd_data;
                            else if (sck_fall && bit_ff != 4'h0)
                                tx_ff <= {tx_ff[6:0], 1'b0};
                            o_data_pin <= {7'h00, tx_ff[7]};
                        end
                    endcase
                end
                default: st_ff <= ST_DET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Write buffer toward register file
    // ----------------------------------------------------------------
    // Full FIFO holds one staged write and drops later ones; the host must pace itself
    hbi_fifo #(
        .WIDTH(`HBI_WR_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_wr_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_in_valid(wr_v),
        .o_in_ready(wr_rdy),
        .i_in_data(wr_d),
        .o_out_valid(o_wr_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data({o_wr_addr, o_wr_data})
    );
endmodule // hbi_host_if
`default_nettype wire

// *** design/hbi_map.vh ***
// Constants for the host bus interface: mode codes, field positions, counts.
// Assumes inclusion by the host interface module and its bench monitor.
`ifndef HBI_MAP_VH
`define HBI_MAP_VH
// Detected interface modes
`define HBI_MODE_SEP_DED 3'h0
`define HBI_MODE_SEP_MUX 3'h1
`define HBI_MODE_COM_DED 3'h2
`define HBI_MODE_COM_MUX 3'h3
`define HBI_MODE_HSK 3'h4
`define HBI_MODE_SPI 3'h5
// SPI first-byte fields
`define HBI_SPI_DIR_BIT 7
`define HBI_SPI_ADDR_HI 6
`define HBI_SPI_ADDR_LO 1
`define HBI_SPI_BITS 4'h8
`define HBI_SPI_LAST_BIT 4'h7
// Strap patterns on high/middle/low address pins
`define HBI_STRAP_SEP_MUX 3'h3
`define HBI_STRAP_COM_MUX 3'h2
`define HBI_STRAP_SPI 3'h1
// FIFO defaults
`define HBI_FIFO_DEPTH 16
`define HBI_FIFO_AW 4
`define HBI_WR_WIDTH 14
`endif

// *** design/hbi_fifo.v ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module hbi_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_ce,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wp_ff;
    reg [AW:0] rp_ff;
    wire full;
    wire empty;
    assign empty = (wp_ff == rp_ff);
    assign full = (wp_ff[AW-1:0] == rp_ff[AW-1:0]) && (wp_ff[AW] != rp_ff[AW]);
    assign o_in_ready = ~full;
    assign o_out_valid = ~empty;
    assign o_out_data = mem[rp_ff[AW-1:0]];
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            wp_ff <= {(AW+1){1'b0}};
            rp_ff <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (i_in_valid && !full) begin
                mem[wp_ff[AW-1:0]] <= i_in_data;
                wp_ff <= wp_ff + 1'b1;
            end
            if (i_out_ready && !empty) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule // hbi_fifo
`default_nettype wire

// *** tb/hbi_host_if_monitor.sv ***
// Concurrent checks on the host bus interface ports.
// Assumes the clock enable drops only while the host pins are idle.
`timescale 1ns/1ps
`include "hbi_map.vh"
`default_nettype none
module hbi_host_if_monitor #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_latch,
    input wire logic [2:0] i_addr_pin,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic i_chip_select_n,
    input wire logic [7:0] i_data_pin,
    input wire logic [7:0] o_data_pin,
    input wire logic o_data_oe,
    input wire logic o_addr0_pin,
    input wire logic o_addr0_oe,
    input wire logic [2:0] o_mode,
    input wire logic o_mode_valid,
    input wire logic [5:0] o_rd_addr,
    input wire logic o_rd_req,
    input wire logic [7:0] i_rd_data,
    input wire logic o_wr_valid,
    input wire logic i_wr_ready,
    input wire logic [5:0] o_wr_addr,
    input wire logic [7:0] o_wr_data,
    input wire logic o_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------
    // Wait output arming, mode, read request and data bus checks
    // ----------------------------------------
    logic seen_fall_ff;
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            seen_fall_ff <= 1'b0;
        end else if (!i_latch) begin
            seen_fall_ff <= 1'b1;
        end
    end
    a_wait_held_off: assert property (o_addr0_oe |-> seen_fall_ff)
        else $error("wait driven before first address strobe");
    a_wait_low_strobe: assert property (o_addr0_oe && $fell(i_read_strobe_n)
        && !i_chip_select_n |-> ##[1:4] !o_addr0_pin) else $error("wait not low");
    a_mode_valid_rise: assert property ($rose(i_rst_b) |-> ##[0:2] o_mode_valid)
        else $error("mode not valid after reset");
    a_mode_stable: assert property (o_mode_valid && $past(o_mode_valid) |-> $stable(o_mode))
        else $error("mode changed");
    a_strobe_to_req: assert property (o_mode == `HBI_MODE_SEP_DED && o_mode_valid
        && $fell(i_read_strobe_n) && !i_chip_select_n |-> ##[1:4] o_rd_req)
        else $error("no read request");
    a_rd_then_drive: assert property (o_rd_req && o_mode != `HBI_MODE_SPI
        |=> o_data_oe && o_data_pin == $past(i_rd_data)) else $error("read data wrong");
    a_oe_drops: assert property ($rose(i_read_strobe_n) && o_mode != `HBI_MODE_SPI
        |-> ##[1:5] !o_data_oe) else $error("data bus held");
    a_miso_bit_zero: assert property (o_mode == `HBI_MODE_SPI && o_data_oe
        |-> o_data_pin[7:1] == 7'h00) else $error("upper data bits driven");
endmodule // hbi_host_if_monitor
bind hbi_host_if hbi_host_if_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW))
    u_hbi_host_if_monitor (.i_ref_clk, .i_rst_b, .i_ce, .i_latch, .i_addr_pin,
    .i_read_strobe_n, .i_write_strobe_n, .i_chip_select_n, .i_data_pin, .o_data_pin,
    .o_data_oe, .o_addr0_pin, .o_addr0_oe, .o_mode, .o_mode_valid, .o_rd_addr, .o_rd_req,
    .i_rd_data, .o_wr_valid, .i_wr_ready, .o_wr_addr, .o_wr_data, .o_busy);
`default_nettype wire

// *** tb/hbi_host_model.sv ***
// Host side model: parallel bus master and SPI master.
// Assumes the bench resolves shared pins before they reach the device.
`timescale 1ns/1ps
`default_nettype none
module hbi_host_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_dev_data,
    output logic o_latch,
    output logic [2:0] o_addr_pin,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic o_chip_select_n,
    output logic [7:0] o_data_pin
);
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask
    task automatic strap(input logic [2:0] m);
        logic [17:0] pins;
        pins = {3'h1, 3'h6, 3'h2, 3'h0, 3'h3, 3'h0};
        o_addr_pin = pins[m*3 +: 3];
        o_latch = m != 3'h1 && m != 3'h3;
        o_write_strobe_n = m != 3'h2;
        o_read_strobe_n = 1'b1;
        o_chip_select_n = m < 3'h4;
        o_data_pin = 8'h00;
    endtask
    // address phase first, never a read-address cycle
    task automatic par_cycle(input logic [2:0] m, input logic wr, input logic [5:0] a,
            input logic [7:0] wd, output logic [7:0] rd);
        o_chip_select_n = 1'b0;
        if (m == 3'h1 || m >= 3'h3) begin
            o_data_pin = {2'h0, a};
            o_latch = ~o_latch;
            tick(4);
            o_latch = ~o_latch;
            tick(4);
        end else begin
            o_addr_pin = a[2:0];
        end
        if (m >= 3'h2) o_write_strobe_n = !wr;
        // Released bus shows a changing pattern
        o_data_pin = wr ? wd : ~o_data_pin;
        if (m < 3'h2 && wr) o_write_strobe_n = 1'b0;
        else o_read_strobe_n = 1'b0;
        tick(6);
        rd = i_dev_data;
        o_read_strobe_n = 1'b1;
        if (m < 3'h2) o_write_strobe_n = 1'b1;
        tick(6);
        o_chip_select_n = m < 3'h4;
        o_data_pin = ~o_data_pin;
    endtask
    // mode 0 byte, MSB first, clock idles low
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_addr_pin[0] = tx[i];
            o_data_pin = ~o_data_pin;
            #100;
            rx[i] = i_dev_data[0];
            o_addr_pin[2] = 1'b1;
            #100;
            o_addr_pin[2] = 1'b0;
        end
    endtask
    // Odd offset keeps link edges apart from the clock
    task automatic spi_frame(input logic open);
        #37;
        o_latch = !open;
        #100;
    endtask
endmodule // hbi_host_model
`default_nettype wire

// *** tb/hbi_host_if_test.sv ***
// Bench for the host bus interface: SPI, parallel styles and handshake.
// Assumes the host model drives host pins and the bench answers reads.
`timescale 1ns/1ps
`default_nettype none
`define HBI_CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    bad_count++; $display("Error %s expected %h seen %h", what, exp, got); end end
module hbi_host_if_test;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_wr_ready = 1'b0;
    logic i_ce = 1'b1;
    logic [7:0] key;
    logic latch, rsn, wsn, csn, doe, a0, a0_oe, mvalid, rreq, wvalid, busy;
    logic [2:0] apin, hpin, mode;
    logic [7:0] din, dout, hdata, rd_data, rx, wdat, wd8;
    logic [5:0] rd_addr, wr_addr, a, msk;
    logic [5:0] adr [3];
    logic [7:0] dq [17];
    int bad_count = 0;
    int compares = 0;
    int seed;
    always #12.5 i_ref_clk = ~i_ref_clk;
    // Shared pins: the device wins while it drives
    assign apin = {hpin[2:1], a0_oe ? a0 : hpin[0]};
    assign din = doe ? dout : hdata;
    // Register file stand-in: every data bit moves with the address
    assign rd_data = {rd_addr, rd_addr[5:4]} ^ key;
    function automatic logic [7:0] exp_rd(input logic [5:0] ad);
        return {ad, ad[5:4]} ^ key;
    endfunction
    hbi_host_if u_hbi_host_if (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_latch(latch), .i_addr_pin(apin), .i_read_strobe_n(rsn), .i_write_strobe_n(wsn),
        .i_chip_select_n(csn), .i_data_pin(din), .o_data_pin(dout), .o_data_oe(doe),
        .o_addr0_pin(a0), .o_addr0_oe(a0_oe), .o_mode(mode), .o_mode_valid(mvalid),
        .o_rd_addr(rd_addr), .o_rd_req(rreq), .i_rd_data(rd_data), .o_wr_valid(wvalid),
        .i_wr_ready(i_wr_ready), .o_wr_addr(wr_addr), .o_wr_data(wdat), .o_busy(busy));
    hbi_host_model u_hbi_host_model (.i_ref_clk(i_ref_clk), .i_dev_data(din),
        .o_latch(latch), .o_addr_pin(hpin), .o_read_strobe_n(rsn),
        .o_write_strobe_n(wsn), .o_chip_select_n(csn), .o_data_pin(hdata));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic restart(input logic [2:0] m);
        i_rst_b = 1'b0;
        u_hbi_host_model.strap(m);
        u_hbi_host_model.tick(3);
        `HBI_CHECK("addr0_oe", 1'b0, a0_oe)
        i_rst_b = 1'b1;
        u_hbi_host_model.tick(6);
        `HBI_CHECK("mode", m, mode)
        `HBI_CHECK("mode_valid", 1'b1, mvalid)
        `HBI_CHECK("wait_idle", 1'b0, a0_oe)
    endtask
    task automatic pop(input logic [5:0] ea, input logic [7:0] ed);
        int n;
        n = 0;
        while (wvalid !== 1'b1) begin
            n++;
            if (n > 400) begin
                bad_count++;
                wrap_up();
            end
            u_hbi_host_model.tick(1);
        end
        `HBI_CHECK("wr_addr", ea, wr_addr)
        `HBI_CHECK("wr_data", ed, wdat)
        i_wr_ready = 1'b1;
        u_hbi_host_model.tick(1);
        i_wr_ready = 1'b0;
        u_hbi_host_model.tick(1 + $urandom_range(2));
    endtask
    initial begin
        seed = $urandom(90);
        key = 8'($urandom);
        restart(3'h5);
        // ----------------------------------------
        // SPI read, top address as corner
        // ----------------------------------------
        for (int k = 0; k < 3; k++) adr[k] = 6'($urandom);
        adr[0] = 6'h3f;
        u_hbi_host_model.spi_frame(1'b1);
        u_hbi_host_model.spi_byte({1'b1, adr[0], 1'b0}, rx);
        for (int k = 1; k <= 3; k++) begin
            u_hbi_host_model.spi_byte(k < 3 ? {1'b0, adr[k % 3], 1'b0} : 8'h00, rx);
            `HBI_CHECK("miso", exp_rd(adr[k - 1]), rx)
        end
        u_hbi_host_model.spi_frame(1'b0);
        $display("spi read done");
        // One byte past the FIFO depth waits staged, sink stalled
        a = 6'($urandom);
        u_hbi_host_model.spi_frame(1'b1);
        u_hbi_host_model.spi_byte({1'b0, a, 1'b0}, rx);
        for (int k = 0; k < 17; k++) begin
            dq[k] = 8'($urandom);
            u_hbi_host_model.spi_byte(dq[k], rx);
        end
        u_hbi_host_model.spi_frame(1'b0);
        u_hbi_host_model.tick(1);
        `HBI_CHECK("busy", 1'b1, busy)
        // Clock enable low: the sink must not drain
        i_ce = 1'b0;
        i_wr_ready = 1'b1;
        u_hbi_host_model.tick(3);
        `HBI_CHECK("frozen_data", dq[0], wdat)
        i_wr_ready = 1'b0;
        i_ce = 1'b1;
        for (int k = 0; k < 17; k++) pop(a, dq[k]);
        `HBI_CHECK("fifo_empty", 1'b0, wvalid)
        `HBI_CHECK("busy_clear", 1'b0, busy)
        $display("spi write done");
        // ----------------------------------------
        // Parallel styles and handshake
        // ----------------------------------------
        for (int m = 0; m < 5; m++) begin
            restart(3'(m));
            msk = (m == 0 || m == 2) ? 6'h07 : 6'h3f;
            a = 6'($urandom) & msk;
            wd8 = 8'($urandom);
            u_hbi_host_model.par_cycle(3'(m), 1'b1, a, wd8, rx);
            `HBI_CHECK("wait_oe", m == 4, a0_oe)
            pop(a, wd8);
            a = 6'($urandom) & msk;
            u_hbi_host_model.par_cycle(3'(m), 1'b0, a, 8'h00, rx);
            `HBI_CHECK("rd_data", exp_rd(a), rx)
            if (m == 4) begin
                u_hbi_host_model.o_chip_select_n = 1'b1;
                u_hbi_host_model.o_read_strobe_n = 1'b0;
                u_hbi_host_model.tick(6);
                `HBI_CHECK("inhibit_oe", 1'b0, doe)
                `HBI_CHECK("inhibit_wait", 1'b1, a0)
                u_hbi_host_model.o_read_strobe_n = 1'b1;
                u_hbi_host_model.tick(6);
            end
            $display("parallel mode %0d done", m);
        end
        wrap_up();
    end
endmodule // hbi_host_if_test
`default_nettype wire
